// File: inc/ppg_pkg.sv
package ppg_pkg;

  // Operation mode code that selects pulse generation
  localparam logic [2:0] PPG_MODE_CODE = 3'h3;

  // Mode byte layout
  localparam int MR_OPM_POS = 0;
  localparam int MR_CKS_POS = 4;
  localparam logic [7:0] MR_RESET = 8'h00;

  // Control byte layout
  localparam int CR_RUN_POS = 0;
  localparam int CR_ONE_POS = 1;
  localparam int CR_TFF_POS = 2;
  localparam int CR_OVE_POS = 3;
  localparam int CR_DBF_POS = 4;
  localparam int CR_NC_POS = 5;
  localparam logic [7:0] CR_RESET = 8'h00;

  // Compare and counter reset values
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [15:0] CNT_CLEAR = 16'h0000;

  // Noise canceller sampling intervals in gear clocks
  localparam int NF_INT_01 = 2;
  localparam int NF_INT_10 = 4;
  localparam int NF_INT_11 = 256;
  // Slow-mode sampling divides the low-frequency tick by this
  localparam int NF_LF_DIV = 2;
  // Equal samples needed before a new level is passed
  localparam int NF_SAMPLES = 3;

  // Prescaler width: longest source clock divide is 2^11
  localparam int PRESC_W = 11;

  typedef enum logic [2:0] {
    WS_MODE,
    WS_CTRL,
    WS_PER_LO,
    WS_PER_HI,
    WS_TOG_LO,
    WS_TOG_HI
  } ppg_wsel_t;

  typedef struct packed {
    logic [2:0] op_mode_field;
    logic [2:0] source_clock_select;
  } ppg_mode_t;

  typedef struct packed {
    logic [1:0] noise_filter_select;
    logic double_buffer_enable;
    logic overflow_irq_enable;
    logic initial_level_flipflop;
    logic one_shot_select;
    logic run_bit;
  } ppg_ctrl_t;

endpackage

// File: core/ppg_noise_filter.sv
`timescale 1ns/1ps
`default_nettype none
module ppg_noise_filter #(
  parameter int SAMPLES = ppg_pkg::NF_SAMPLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  input wire logic [1:0] sel,
  input wire logic slow_mode,
  input wire logic lf_tick,
  output logic dout
);
  import ppg_pkg::*;

  localparam logic [7:0] MASK_01 = 8'(NF_INT_01 - 1);
  localparam logic [7:0] MASK_10 = 8'(NF_INT_10 - 1);
  localparam logic [7:0] MASK_11 = 8'(NF_INT_11 - 1);
  localparam logic [1:0] LF_LAST = 2'(NF_LF_DIV - 1);

  logic [7:0] div_q;
  logic [1:0] lf_q;
  logic [SAMPLES-2:0] hist_q;
  logic filt_q;
  logic dout_q;
  wire logic [7:0] mask;
  wire logic fast_smp;
  wire logic slow_smp;
  wire logic smp;
  wire logic blocked;
  wire logic all_hi;
  wire logic all_lo;

  assign mask = (sel == 2'h1) ? MASK_01 : (sel == 2'h2) ? MASK_10 : MASK_11;
  assign fast_smp = ((div_q & mask) == mask);
  assign slow_smp = lf_tick && (lf_q == LF_LAST);
  // Slow clocking only offers the longest interval
  assign blocked = slow_mode && (sel != 2'h0) && (sel != 2'h3); // RULE_21
  assign smp = slow_mode ? slow_smp : fast_smp; // RULE_19
  assign all_hi = din && (&hist_q);
  assign all_lo = !din && !(|hist_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      div_q <= 8'h00;
      lf_q <= 2'h0;
    end else begin
      div_q <= div_q + 8'h01;
      if (lf_tick) begin
        lf_q <= (lf_q == LF_LAST) ? 2'h0 : lf_q + 2'h1;
      end
    end
  end

  // Runs whenever a filter is chosen, independent of the timer state
  always_ff @(posedge clk) begin
    if (srst) begin
      hist_q <= '0;
      filt_q <= 1'b0;
    end else if (sel != 2'h0 && smp) begin // RULE_18
      hist_q <= {hist_q[SAMPLES-3:0], din};
      if (all_hi || all_lo) begin
        filt_q <= din;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dout_q <= 1'b0;
    end else if (sel == 2'h0) begin
      dout_q <= din;
    end else begin
      dout_q <= blocked ? 1'b0 : filt_q;
    end
  end

  assign dout = dout_q;

  AST_NF_STABLE: assert property (@(posedge clk) disable iff (srst) // RULE_18
      sel != 2'h0 && smp && !all_hi && !all_lo |=> $stable(filt_q))
    else $error("filter output changed without equal samples");

endmodule // ppg_noise_filter
`default_nettype wire

// File: core/ppg_timer.sv
// Contract
// RULE_01: Mode code 011 selects pulse mode, clock select
// RULE_02: Period compare sets cycle, toggle compare first edge
// RULE_03: Software keeps period compare above toggle compare
// RULE_04: Flip-flop bit sets idle output level
// RULE_05: Run starts; mode, overflow, flip-flop locked
// RULE_06: Toggle match drives output opposite idle level
// RULE_07: Period match restores idle level, raises interrupt
// RULE_08: One-shot period match clears run bit
// RULE_09: Continuous period match clears counter, keeps running
// RULE_10: Any stop returns output to idle level
// RULE_11: One-shot bit writable while running
// RULE_12: Low byte buffered, high write commits both
// RULE_13: Software writes low byte before high byte
// RULE_14: Double buffer loads compares at period match
// RULE_15: Buffered reads return last written value
// RULE_16: Stopped writes update effective and buffer
// RULE_17: Unbuffered writes immediate; counter may wrap
// RULE_18: Filter needs three equal samples, runs always
// RULE_19: Filter intervals 2, 4, 256 gear clocks
// RULE_20: Filter select locked while running
// RULE_21: Slow mode: 11 uses fs/2, others block
// RULE_22: Software waits four intervals before start
// RULE_23: Clearing run stops and zeroes counter
// RULE_24: Sixteen-bit counter, compares as byte pairs
`timescale 1ns/1ps
`default_nettype none
module ppg_timer #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire ppg_pkg::ppg_wsel_t wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic slow_mode,
  input wire logic lf_tick,
  input wire logic timer_input_pin,
  output logic pulse_out_pin,
  output logic timer_irq,
  output logic timer_input_filtered,
  output ppg_pkg::ppg_mode_t mode_rd,
  output ppg_pkg::ppg_ctrl_t ctrl_rd,
  output logic [CNT_W-1:0] period_rd,
  output logic [CNT_W-1:0] toggle_rd,
  output logic [CNT_W-1:0] count_rd
);
  import ppg_pkg::*;

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(CNT_CLEAR);
  localparam logic [CNT_W-1:0] CMP_INIT = CNT_W'(CMP_RESET);

  ppg_mode_t mode_q;
  ppg_ctrl_t ctrl_q;
  ppg_ctrl_t ctrl_d;
  logic [PRESC_W-1:0] presc_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] per_eff_q;
  logic [CNT_W-1:0] per_buf_q;
  logic [CNT_W-1:0] tog_eff_q;
  logic [CNT_W-1:0] tog_buf_q;
  logic [CNT_W-1:0] per_rd_q;
  logic [CNT_W-1:0] tog_rd_q;
  logic [7:0] tmp_q;
  logic out_q;
  logic out_d;
  logic irq_q;
  logic pin_s1_q;
  logic pin_s2_q;

  // Divide exponent of the internal source clock selection
  function automatic logic [3:0] clk_exp(input logic [2:0] s);
    case (s)
      3'h0: clk_exp = 4'hb;
      3'h1: clk_exp = 4'ha;
      3'h2: clk_exp = 4'h8;
      3'h3: clk_exp = 4'h6;
      3'h4: clk_exp = 4'h4;
      3'h5: clk_exp = 4'h2;
      3'h6: clk_exp = 4'h1;
      default: clk_exp = 4'h0;
    endcase
  endfunction

  wire logic wr_mode;
  wire logic wr_ctrl;
  wire logic wr_per_lo;
  wire logic wr_per_hi;
  wire logic wr_tog_lo;
  wire logic wr_tog_hi;
  wire logic [CNT_W-1:0] cmp_val;
  wire logic [PRESC_W-1:0] tick_mask;
  wire logic int_tick;
  wire logic tick;
  wire logic is_ppg;
  wire logic running;
  wire logic hold_wr;
  wire logic adv;
  wire logic match_a;
  wire logic match_b;
  wire logic os_stop;

  assign wr_mode = wr_en && (wr_sel == WS_MODE);
  assign wr_ctrl = wr_en && (wr_sel == WS_CTRL);
  assign wr_per_lo = wr_en && (wr_sel == WS_PER_LO);
  assign wr_per_hi = wr_en && (wr_sel == WS_PER_HI);
  assign wr_tog_lo = wr_en && (wr_sel == WS_TOG_LO);
  assign wr_tog_hi = wr_en && (wr_sel == WS_TOG_HI);
  // High byte joins the buffered low byte into one word
  assign cmp_val = {wr_data, tmp_q}; // RULE_12

  assign tick_mask = PRESC_W'((12'h001 << clk_exp(mode_q.source_clock_select))
                     - 12'h001);
  assign int_tick = ((presc_q & tick_mask) == tick_mask);
  // Slow modes count on the low-frequency tick only
  assign tick = slow_mode ? lf_tick : int_tick; // RULE_01
  assign is_ppg = (mode_q.op_mode_field == PPG_MODE_CODE); // RULE_01
  assign running = ctrl_q.run_bit;
  assign hold_wr = running && ctrl_q.double_buffer_enable;
  assign adv = running && is_ppg && tick;
  assign match_a = adv && (cnt_q == per_eff_q); // RULE_02
  assign match_b = adv && (cnt_q == tog_eff_q) && !match_a; // RULE_02
  assign os_stop = match_a && ctrl_q.one_shot_select; // RULE_08 RULE_11

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      presc_q <= '0;
    end else begin
      pin_s1_q <= timer_input_pin;
      pin_s2_q <= pin_s1_q;
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // A software write in the stop cycle wins, so a restart is never lost
  always_comb begin
    ctrl_d = ctrl_q;
    if (os_stop) begin
      ctrl_d.run_bit = 1'b0; // RULE_08
    end
    if (wr_ctrl) begin
      ctrl_d.run_bit = wr_data[CR_RUN_POS]; // RULE_05
      ctrl_d.one_shot_select = wr_data[CR_ONE_POS]; // RULE_11
      ctrl_d.double_buffer_enable = wr_data[CR_DBF_POS];
      if (!running) begin // RULE_05 RULE_20
        ctrl_d.initial_level_flipflop = wr_data[CR_TFF_POS];
        ctrl_d.overflow_irq_enable = wr_data[CR_OVE_POS];
        ctrl_d.noise_filter_select = wr_data[CR_NC_POS +: 2];
      end
    end
  end

  always_comb begin
    if (!ctrl_d.run_bit) begin
      cnt_d = CNT_ZERO; // RULE_23
    end else if (match_a) begin
      cnt_d = CNT_ZERO; // RULE_09
    end else if (adv) begin
      // Free wrap lets a lowered compare be met after overflow
      cnt_d = cnt_q + CNT_ONE; // RULE_17 RULE_24
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_comb begin
    if (!ctrl_d.run_bit) begin
      out_d = ctrl_d.initial_level_flipflop; // RULE_04 RULE_10
    end else if (match_a) begin
      out_d = ctrl_q.initial_level_flipflop; // RULE_07
    end else if (match_b) begin
      out_d = !ctrl_q.initial_level_flipflop; // RULE_06
    end else begin
      out_d = out_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= ppg_ctrl_t'(CR_RESET[6:0]);
      mode_q <= '0;
      cnt_q <= CNT_ZERO;
      out_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_mode && !running) begin // RULE_05
        mode_q.op_mode_field <= wr_data[MR_OPM_POS +: 3];
        mode_q.source_clock_select <= wr_data[MR_CKS_POS +: 3];
      end
      cnt_q <= cnt_d;
      out_q <= out_d;
      irq_q <= match_a; // RULE_07
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tmp_q <= 8'h00;
    end else if (wr_per_lo || wr_tog_lo) begin
      tmp_q <= wr_data; // RULE_12
    end
  end

  // The buffer always tracks the last write so reads stay coherent
  always_ff @(posedge clk) begin
    if (srst) begin
      per_eff_q <= CMP_INIT;
      per_buf_q <= CMP_INIT;
      tog_eff_q <= CMP_INIT;
      tog_buf_q <= CMP_INIT;
    end else begin
      if (wr_per_hi) begin
        per_buf_q <= cmp_val; // RULE_16
      end
      if (wr_tog_hi) begin
        tog_buf_q <= cmp_val; // RULE_16
      end
      if (wr_per_hi && !hold_wr) begin
        per_eff_q <= cmp_val; // RULE_16 RULE_17
      end else if (match_a && ctrl_q.double_buffer_enable) begin
        per_eff_q <= per_buf_q; // RULE_14
      end
      if (wr_tog_hi && !hold_wr) begin
        tog_eff_q <= cmp_val; // RULE_16 RULE_17
      end else if (match_a && ctrl_q.double_buffer_enable) begin
        tog_eff_q <= tog_buf_q; // RULE_14
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      per_rd_q <= CMP_INIT;
      tog_rd_q <= CMP_INIT;
    end else begin
      per_rd_q <= ctrl_q.double_buffer_enable ? per_buf_q // RULE_15
                  : per_eff_q;
      tog_rd_q <= ctrl_q.double_buffer_enable ? tog_buf_q // RULE_15
                  : tog_eff_q;
    end
  end

  ppg_noise_filter #(
    .SAMPLES(NF_SAMPLES)
  ) u_filter (
    .clk(clk),
    .srst(srst),
    .din(pin_s2_q),
    .sel(ctrl_q.noise_filter_select),
    .slow_mode(slow_mode),
    .lf_tick(lf_tick),
    .dout(timer_input_filtered)
  );

  assign pulse_out_pin = out_q;
  assign timer_irq = irq_q;
  assign mode_rd = mode_q;
  assign ctrl_rd = ctrl_q;
  assign period_rd = per_rd_q;
  assign toggle_rd = tog_rd_q;
  assign count_rd = cnt_q;

  // Every check runs on the one clock and rests while reset is high
  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_per_pair;
    wr_per_lo ##1 wr_per_hi;
  endsequence

  sequence s_os_hit;
    match_a && ctrl_q.one_shot_select && !wr_ctrl;
  endsequence

  // Software may legally restart in the cycle after the stop
  sequence s_os_held;
    !ctrl_q.run_bit ##1 (!ctrl_q.run_bit || $past(wr_ctrl));
  endsequence

  sequence s_tog_stopped_wr;
    !running && wr_tog_hi;
  endsequence

  sequence s_tog_both_then_rd;
    tog_eff_q == tog_buf_q ##1 toggle_rd == $past(tog_eff_q);
  endsequence

  AST_PAIR_COMMIT: assert property ( // RULE_12
      s_per_pair |=> per_buf_q == {$past(wr_data), $past(wr_data, 2)})
    else $error("byte pair not committed as one word");

  AST_ONESHOT_STOP: assert property ( // RULE_08
      s_os_hit |=> s_os_held)
    else $error("one-shot did not stop at period match");

  AST_IRQ_ON_A: assert property ( // RULE_07
      match_a |=> timer_irq
      && pulse_out_pin == $past(ctrl_q.initial_level_flipflop))
    else $error("period match without interrupt or idle level");

  AST_TOGGLE_B: assert property ( // RULE_06
      match_b && !wr_ctrl
      |=> pulse_out_pin != ctrl_q.initial_level_flipflop)
    else $error("toggle match did not invert output");

  AST_IDLE_LEVEL: assert property ( // RULE_10
      !ctrl_q.run_bit |-> pulse_out_pin == ctrl_q.initial_level_flipflop)
    else $error("stopped output not at idle level");

  AST_CONT_CLEAR: assert property ( // RULE_09
      match_a && !ctrl_q.one_shot_select && !wr_ctrl
      |=> cnt_q == CNT_ZERO && ctrl_q.run_bit)
    else $error("continuous period match did not clear counter");

  AST_MODE_LOCK: assert property ( // RULE_05
      running && wr_mode |=> $stable(mode_q))
    else $error("mode changed while running");

  AST_NC_LOCK: assert property ( // RULE_20
      running && wr_ctrl |=> $stable(ctrl_q.noise_filter_select)
      && $stable(ctrl_q.initial_level_flipflop))
    else $error("locked control field changed while running");

  AST_DBUF_HOLD: assert property ( // RULE_14
      hold_wr && wr_per_hi && !match_a |=> $stable(per_eff_q))
    else $error("buffered write took effect early");

  AST_TOG_DBUF_HOLD: assert property ( // RULE_14
      hold_wr && wr_tog_hi && !match_a |=> $stable(tog_eff_q))
    else $error("buffered toggle write took effect early");

  AST_DBUF_LOAD: assert property ( // RULE_14
      match_a && ctrl_q.double_buffer_enable && !wr_per_hi
      |=> per_eff_q == $past(per_buf_q))
    else $error("buffered period not loaded at period match");

  AST_STOP_CLEAR: assert property ( // RULE_23
      !ctrl_q.run_bit |-> cnt_q == CNT_ZERO)
    else $error("counter not zero while stopped");

  AST_STOPPED_WRITE: assert property ( // RULE_16
      s_tog_stopped_wr |=> s_tog_both_then_rd)
    else $error("stopped write did not reach both registers");

endmodule // ppg_timer
`default_nettype wire

// File: bench/ppg_ext_ckt.sv
`timescale 1ns/1ps
`default_nettype none
module ppg_ext_ckt (
  input wire logic clk,
  input wire logic pulse_out_pin,
  output logic timer_input_pin
);
  int edges;
  logic last_q;

  initial begin
    timer_input_pin = 1'b0;
    edges = 0;
    last_q = 1'b0;
  end

  // The load only counts level changes; the bench judges how many it expects
  always @(posedge clk) begin
    if (pulse_out_pin !== last_q) edges <= edges + 1;
    last_q <= pulse_out_pin;
  end

  // A push-pull source: the pin always shows a driven level
  task automatic pulse_pin(input logic lvl, input int n);
    logic prev;
    prev = timer_input_pin;
    timer_input_pin = lvl;
    repeat (n) @(posedge clk);
    #1;
    timer_input_pin = prev;
  endtask

  task automatic set_pin(input logic lvl);
    timer_input_pin = lvl;
  endtask
endmodule // ppg_ext_ckt
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppg_pkg::*;
  logic clk, srst, wr_en, slow_mode, lf_tick, lf_run, tin, pout, irq, filt;
  ppg_wsel_t wr_sel;
  logic [7:0] wr_data;
  ppg_mode_t mode_rd;
  ppg_ctrl_t ctrl_rd;
  logic [15:0] period_rd, toggle_rd, count_rd;
  int errors, cmp_count, cycles, n, e0;
  int ivs [4] = '{0, 2, 4, 256};
  logic [2:0] exp_c [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1};
  logic [1:0] exp_oi [6] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h0};

  ppg_timer dut (.clk(clk), .srst(srst), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .slow_mode(slow_mode),
    .lf_tick(lf_tick), .timer_input_pin(tin), .pulse_out_pin(pout),
    .timer_irq(irq), .timer_input_filtered(filt), .mode_rd(mode_rd),
    .ctrl_rd(ctrl_rd), .period_rd(period_rd), .toggle_rd(toggle_rd),
    .count_rd(count_rd));
  ppg_ext_ckt ext (.clk(clk), .pulse_out_pin(pout), .timer_input_pin(tin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Slow clock stand-in: one tick every fourth gear clock
  always @(posedge clk) begin
    cycles <= cycles + 1;
    lf_tick <= #1 lf_run && (cycles % 4 == 0);
    if (cycles == 20000) begin
      errors++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Strobe stays up between back-to-back writes; done() drops it
  task automatic wr(input ppg_wsel_t s, input logic [7:0] d);
    wr_en = 1'b1;
    wr_sel = s;
    wr_data = d;
    tick(1);
  endtask

  task automatic done();
    wr_en = 1'b0;
  endtask

  task automatic wait_irq(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (irq !== 1'b1 && k < 2000);
  endtask

  initial begin
    srst = 1'b1; wr_en = 1'b0; wr_sel = WS_MODE; wr_data = 8'h00;
    slow_mode = 1'b0; lf_tick = 1'b0; lf_run = 1'b0; cycles = 0;
    errors = 0; cmp_count = 0;
    tick(6);
    srst = 1'b0;
    chk({9'h000, ctrl_rd}, 16'h0000, "ctrl reset");
    chk(period_rd, 16'hffff, "period reset");
    chk(toggle_rd, 16'hffff, "toggle reset");
    chk({15'h0000, pout}, 16'h0000, "out reset");
    $display("test reset done");

    wr(WS_MODE, 8'h73);
    wr(WS_PER_LO, 8'h03); wr(WS_PER_HI, 8'h00);
    wr(WS_TOG_LO, 8'h01); wr(WS_TOG_HI, 8'h00);
    wr(WS_CTRL, 8'h01); done();
    for (int i = 0; i < 6; i++) begin
      chk(count_rd, {13'h0000, exp_c[i]}, "walk count");
      chk({14'h0000, pout, irq}, {14'h0000, exp_oi[i]}, "walk out");
      tick(1);
    end
    chk({10'h000, mode_rd}, 16'h001f, "mode");
    $display("test continuous done");

    wr(WS_MODE, 8'h00); wr(WS_CTRL, 8'h6d); done(); tick(1);
    chk({10'h000, mode_rd}, 16'h001f, "mode lock");
    chk({9'h000, ctrl_rd}, 16'h0001, "ctrl lock");
    n = 0;
    while (pout !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    wr(WS_CTRL, 8'h00); done();
    chk(count_rd, 16'h0000, "stop count");
    chk({15'h0000, pout}, 16'h0000, "stop out");
    $display("test lock and stop done");

    tick(1);
    wr(WS_CTRL, 8'h04); done(); tick(2);
    chk({15'h0000, pout}, 16'h0001, "idle high");
    e0 = ext.edges;
    wr(WS_CTRL, 8'h05); wr(WS_CTRL, 8'h07); done();
    wait_irq(n);
    chk({15'h0000, ctrl_rd.run_bit}, 16'h0000, "one-shot stop");
    chk({15'h0000, pout}, 16'h0001, "one-shot out");
    tick(8);
    chk(count_rd, 16'h0000, "held count");
    chk(16'(ext.edges - e0), 16'h0002, "one pulse");
    $display("test one-shot done");

    wr(WS_CTRL, 8'h14); wr(WS_PER_LO, 8'h05); done(); tick(2);
    chk(period_rd, 16'h0003, "low byte alone");
    wr(WS_PER_HI, 8'h00); done(); tick(2);
    chk(period_rd, 16'h0005, "stopped write");
    wr(WS_CTRL, 8'h15); wr(WS_TOG_LO, 8'h02); wr(WS_TOG_HI, 8'h00);
    wr(WS_PER_LO, 8'h09); wr(WS_PER_HI, 8'h00); done();
    chk(toggle_rd, 16'h0002, "buffer read");
    wait_irq(n);
    chk(16'(n), 16'h0002, "old period");
    chk(period_rd, 16'h0009, "period buffer");
    wait_irq(n);
    chk(16'(n), 16'h000a, "new period");
    wr(WS_CTRL, 8'h04); done();
    $display("test double buffer done");

    tick(1);
    wr(WS_CTRL, 8'h05); wr(WS_PER_LO, 8'h06); wr(WS_PER_HI, 8'h00); done();
    wait_irq(n);
    chk(16'(n), 16'h0005, "immediate period");
    wr(WS_CTRL, 8'h04); done();
    $display("test direct write done");

    tick(1);
    wr(WS_MODE, 8'h53); wr(WS_CTRL, 8'h05); done();
    wait_irq(n);
    wait_irq(n);
    chk(16'(n), 16'h001c, "divided period");
    wr(WS_CTRL, 8'h04); done();
    $display("test clock select done");

    ext.set_pin(1'b1); tick(6);
    chk({15'h0000, filt}, 16'h0001, "unfiltered high");
    ext.set_pin(1'b0); tick(6);
    chk({15'h0000, filt}, 16'h0000, "unfiltered low");
    for (int s = 1; s < 4; s++) begin
      wr(WS_CTRL, {1'b0, s[1:0], 5'h00}); done();
      tick(4 * ivs[s]);
      ext.pulse_pin(1'b1, 2 * ivs[s]);
      n = 0;
      repeat (4 * ivs[s] + 8) begin
        tick(1);
        if (filt !== 1'b0) n++;
      end
      chk(16'(n), 16'h0000, "glitch passed");
      ext.set_pin(1'b1); tick(ivs[s]);
      chk({15'h0000, filt}, 16'h0000, "early level");
      tick(3 * ivs[s] + 8);
      chk({15'h0000, filt}, 16'h0001, "filtered high");
      ext.set_pin(1'b0); tick(4 * ivs[s] + 8);
      chk({15'h0000, filt}, 16'h0000, "filtered low");
    end
    $display("test noise filter done");

    slow_mode = 1'b1;
    lf_run = 1'b1;
    wr(WS_CTRL, 8'h20); done();
    ext.set_pin(1'b1); tick(40);
    chk({15'h0000, filt}, 16'h0000, "slow blocked");
    wr(WS_CTRL, 8'h60); done(); tick(60);
    chk({15'h0000, filt}, 16'h0001, "slow sampled");
    ext.set_pin(1'b0); tick(12);
    chk({15'h0000, filt}, 16'h0001, "slow hold");
    tick(24);
    chk({15'h0000, filt}, 16'h0000, "slow fall");
    $display("test slow filter done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
